/* File: src/mpt_defs.svh */
`ifndef MPT_DEFS_SVH
`define MPT_DEFS_SVH
`define MPT_NUM_CH 8
`define MPT_NUM_PAIR 4
`define MPT_CNT_RST 16'h0000
`define MPT_PER_RST 8'hff
`define MPT_DUTY_RST 8'h00
`endif

/* File: src/mpt_pkg.sv */
package mpt_pkg;
    typedef logic [7:0] mpt_byte_t;
    typedef logic [15:0] mpt_word_t;
    typedef enum logic [1:0] {
        MPT_UP = 2'b01,
        MPT_DOWN = 2'b10
    } mpt_dir_t;
endpackage

/* File: src/mpt_chan.sv */
`include "mpt_defs.svh"
// One modulator on a 16-bit counter; an 8-bit channel uses the low byte only.
module mpt_chan
    import mpt_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Settings
    input wire logic enable,
    input wire logic wide,
    input wire logic center,
    input wire logic pcm,
    input wire logic polarity,
    input wire mpt_word_t period,
    input wire mpt_word_t duty,
    // Waveform
    output logic wave
);
    mpt_word_t cnt_r, cnt_nxt;
    mpt_dir_t dir_r, dir_nxt;
    mpt_word_t acc_r, acc_nxt;
    logic wave_r, wave_nxt;
    logic [16:0] acc_sum;
    logic at_top, at_zero, active, pcm_hit, full;
    mpt_word_t per_m, duty_m;

    assign per_m = wide ? period : {8'h00, period[7:0]};
    assign duty_m = wide ? duty : {8'h00, duty[7:0]};
    assign at_top = (cnt_r >= per_m - 16'h0001) || (per_m == 16'h0000);
    assign at_zero = (cnt_r == 16'h0000);
    // Density modulation: duty accumulator reaching the period spreads active time
    assign acc_sum = {1'b0, acc_r} + {1'b0, duty_m};
    assign pcm_hit = (acc_sum >= {1'b0, per_m}) && (per_m != 16'h0000);
    // Full is decided on settings alone, so a counter left above a lowered period
    // cannot punch a gap into a 100% output
    assign full = (duty_m >= per_m) && (per_m != 16'h0000); // R03
    // Zero duty never matches; zero period stays inactive
    assign active = full || (pcm ? pcm_hit : ((per_m != 16'h0000) && (cnt_r < duty_m))); // R03
    assign wave_nxt = enable ? (active ~^ polarity) : ~polarity; // R05

    always_comb begin
        cnt_nxt = cnt_r;
        dir_nxt = dir_r;
        acc_nxt = acc_r;
        if (!enable) begin
            cnt_nxt = 16'h0000;
            dir_nxt = MPT_UP;
            acc_nxt = 16'h0000;
        end else if (pcm) begin
            acc_nxt = pcm_hit ? acc_sum[15:0] - per_m : acc_sum[15:0];
            cnt_nxt = at_top ? 16'h0000 : cnt_r + 16'h0001;
        end else if (!center) begin
            cnt_nxt = at_top ? 16'h0000 : cnt_r + 16'h0001; // R06
        end else begin
            case (dir_r)
                MPT_UP: begin
                    if (at_top) begin
                        dir_nxt = MPT_DOWN; // R06
                        cnt_nxt = (cnt_r == 16'h0000) ? cnt_r : cnt_r - 16'h0001;
                    end else begin
                        cnt_nxt = cnt_r + 16'h0001;
                    end
                end
                MPT_DOWN: begin
                    if (at_zero) begin
                        dir_nxt = MPT_UP;
                        cnt_nxt = cnt_r + 16'h0001;
                    end else begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end
                end
                default: begin
                    dir_nxt = MPT_UP;
                    cnt_nxt = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cnt_r <= `MPT_CNT_RST;
            dir_r <= MPT_UP;
            acc_r <= 16'h0000;
            wave_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            dir_r <= dir_nxt;
            acc_r <= acc_nxt;
            wave_r <= wave_nxt;
        end
    end

    assign wave = wave_r;
endmodule

/* File: src/mpt_timer.sv */
// Notes on behaviour
// R01 - Eight 8-bit channels, each with its own counter, period and duty.
// R02 - Each enabled channel, except the lower one of a joined pair, runs its waveform continuously and on its own.
// R03 - Duty covers 0% (never active) through 100% (always active).
// R04 - A density mode spreads the active time across the period.
// R05 - Each output's active level is selected per channel.
// R06 - Left aligned counts up and wraps; center aligned counts up then down.
// R07 - Pairs 7:6, 5:4, 3:2 and 1:0 can join into 16-bit channels.
// R08 - Each pair joins independently of the others.
// R09 - A joined pair drives the higher channel's pin; the lower gives the low period and duty bytes and its pin idles.
`include "mpt_defs.svh"
module mpt_timer
    import mpt_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Per-channel control and per-pair join
    input wire logic [7:0] ch_enable,
    input wire logic [7:0] ch_polarity,
    input wire logic [7:0] ch_center,
    input wire logic [7:0] ch_pcm,
    input wire logic [3:0] pair_join,
    // Per-channel period and duty, channel n in bits 8n+7:8n
    input wire logic [63:0] ch_period,
    input wire logic [63:0] ch_duty,
    // Pins
    output logic [7:0] pwm_out
);
    logic [7:0] wave;
    logic [7:0] wide;
    logic [7:0] run;

    ////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < `MPT_NUM_CH; g++) begin : g_ch
            localparam int P = g / 2;
            localparam int HI = (g % 2 == 1) ? 1 : 0;
            mpt_word_t per_w, duty_w;
            // High channel of a joined pair owns the upper byte; unjoined, own byte only
            assign per_w = wide[g] ? {ch_period[8*g +: 8], ch_period[8*(g-HI) +: 8]}
                                   : {8'h00, ch_period[8*g +: 8]}; // R07
            assign duty_w = wide[g] ? {ch_duty[8*g +: 8], ch_duty[8*(g-HI) +: 8]}
                                    : {8'h00, ch_duty[8*g +: 8]}; // R07
            assign wide[g] = pair_join[P] & (HI == 1); // R08
            // Lower channel idles while joined
            assign run[g] = ch_enable[g] & ~(pair_join[P] & (HI == 0)); // R09
            mpt_chan u_chan (
                .clock(clock),
                .reset(reset),
                .enable(run[g]), // R02
                .wide(wide[g]),
                .center(ch_center[g]),
                .pcm(ch_pcm[g]), // R04
                .polarity(ch_polarity[g]),
                .period(per_w),
                .duty(duty_w),
                .wave(wave[g])
            ); // R01
        end
    endgenerate

    assign pwm_out = wave;

    ////////////////////////////////////////////////////////////////
    // Pins lag settings by one edge, so levels are held against last cycle's polarity
    property p_off_idle;
        @(posedge clock) disable iff (reset)
        !run[0] |=> pwm_out[0] == ~$past(ch_polarity[0]);
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("idle level wrong"); // R02
    property p_zero;
        @(posedge clock) disable iff (reset)
        run[3] && !ch_pcm[3] && !wide[3] && ch_duty[31:24] == 8'h00
        |=> pwm_out[3] == ~$past(ch_polarity[3]);
    endproperty
    a_zero: assert property (p_zero) else $error("zero duty went active"); // R03
    property p_full;
        @(posedge clock) disable iff (reset)
        run[4] && ch_period[39:32] != 8'h00 && ch_duty[39:32] >= ch_period[39:32]
        |=> pwm_out[4] == $past(ch_polarity[4]);
    endproperty
    a_full: assert property (p_full) else $error("full duty not active"); // R03
    property p_join_low;
        @(posedge clock) disable iff (reset)
        pair_join[0] |=> pwm_out[0] == ~$past(ch_polarity[0]);
    endproperty
    a_join_low: assert property (p_join_low) else $error("joined low pin toggled"); // R09
    property p_indep;
        @(posedge clock) disable iff (reset)
        pair_join[0] && !pair_join[1] |-> run[2] == ch_enable[2] && !wide[3];
    endproperty
    a_indep: assert property (p_indep) else $error("pair join leaked"); // R08
    property p_wide;
        @(posedge clock) disable iff (reset)
        wide[7] == pair_join[3] && !wide[6];
    endproperty
    a_wide: assert property (p_wide) else $error("wide select wrong"); // R07
    property p_idle_pol;
        @(posedge clock) disable iff (reset)
        !ch_enable[5] |=> pwm_out[5] == ~$past(ch_polarity[5]);
    endproperty
    a_idle_pol: assert property (p_idle_pol) else $error("disabled pin level wrong"); // R05
    c_join: cover property (@(posedge clock) pair_join[0] && $rose(pwm_out[1]));
    c_center: cover property (@(posedge clock) ch_center[6] && $fell(pwm_out[6]));
    c_pcm: cover property (@(posedge clock) ch_pcm[7] && $rose(pwm_out[7]));
endmodule

/* File: dv/mpt_timer_test.sv */
module mpt_timer_test;
    timeunit 1ns;
    timeprecision 100ps;
    import mpt_pkg::*;

    logic clock;
    logic reset;
    logic [7:0] ch_enable;
    logic [7:0] ch_polarity;
    logic [7:0] ch_center;
    logic [7:0] ch_pcm;
    logic [3:0] pair_join;
    logic [63:0] ch_period;
    logic [63:0] ch_duty;
    logic [7:0] pwm_out;
    int n_fail;
    int checked;
    int hi [8];
    int tg [8];
    // Window is a whole number of every channel's cycle, so counts are phase free
    int exp_hi [8] = '{0, 384, 384, 0, 768, 576, 384, 384};
    int exp_tg [8] = '{0, 6, 384, 0, 0, 384, 256, 768};

    ////////////////////////////////////////////////////////////////
    mpt_timer dut (
        .clock(clock),
        .reset(reset),
        .ch_enable(ch_enable),
        .ch_polarity(ch_polarity),
        .ch_center(ch_center),
        .ch_pcm(ch_pcm),
        .pair_join(pair_join),
        .ch_period(ch_period),
        .ch_duty(ch_duty),
        .pwm_out(pwm_out)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %0d expected %0d", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Count high cycles and edges per pin after a settling time
    task automatic measure(input int w);
        logic [7:0] prev;
        for (int i = 0; i < 8; i++) begin
            hi[i] = 0;
            tg[i] = 0;
        end
        repeat (16) @(posedge clock);
        #1 prev = pwm_out;
        for (int c = 0; c < w; c++) begin
            @(posedge clock);
            #1;
            for (int i = 0; i < 8; i++) begin
                hi[i] += int'(pwm_out[i]);
                tg[i] += int'(pwm_out[i] != prev[i]);
            end
            prev = pwm_out;
        end
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        n_fail = 0;
        checked = 0;
        reset = 1'b1;
        ch_enable = 8'h00;
        ch_polarity = 8'h00;
        ch_center = 8'h00;
        ch_pcm = 8'h00;
        pair_join = 4'h0;
        ch_period = 64'h0;
        ch_duty = 64'h0;
        repeat (5) @(posedge clock);
        #1 check(32'(pwm_out), 32'h0);
        reset = 1'b0;
        // Ch1:0 joined 128/256, ch2 left 2/4, ch3 0%, ch4 100%,
        // ch5 active low 1/4, ch6 centered, ch7 density mode
        ch_enable = 8'hff;
        ch_polarity = 8'hdf;
        ch_center = 8'h40;
        ch_pcm = 8'h80;
        pair_join = 4'h1;
        ch_period = 64'h0404_0404_0404_0100;
        ch_duty = 64'h0202_0104_0002_0080;
        measure(768);
        for (int i = 0; i < 8; i++) begin
            check(32'(hi[i]), 32'(exp_hi[i]));
            check(32'(tg[i]), 32'(exp_tg[i]));
        end
        ch_enable = 8'h00;
        ch_polarity = 8'h0f;
        measure(8);
        check(32'(pwm_out), 32'hf0);
        check(32'(tg[0] + tg[4]), 32'h0);
        @(posedge clock);
        #1 reset = 1'b1;
        @(posedge clock);
        #1 check(32'(pwm_out), 32'h0);
        end_sim();
    end
endmodule
